/* src/nsr_pkg.sv */
package nsr_pkg;
   // ****************************************
   // Geometry
   // ****************************************
   localparam int ADDR_W = 11;
   localparam int DATA_W = 8;
   localparam int CNT_W = 20;

   // ****************************************
   // Timing, nanoseconds as printed
   // ****************************************
   localparam int CLK_NS = 20;
   localparam int T_ACCESS_NS = 45;
   localparam int T_WPULSE_NS = 30;
   localparam int T_HSB_PULSE_NS = 15;
   localparam int T_HSB_LOW_NS = 300;
   localparam int T_RECOVER_NS = 700;
   localparam int T_RECALL_NS = 550000;
   localparam int T_STORE_NS = 10000000;
   localparam int SYNC_CYC = 3;

   // All times round up except the store limit, which rounds down
   localparam int ACCESS_CYC = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS;
   localparam int WPULSE_CYC = (T_WPULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int HSB_PULSE_CYC = (T_HSB_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int HSB_LOW_CYC = (T_HSB_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int RECOVER_CYC = (T_RECOVER_NS + CLK_NS - 1) / CLK_NS;
   localparam int RECALL_CYC = (T_RECALL_NS + CLK_NS - 1) / CLK_NS;
   localparam int STORE_CYC = T_STORE_NS / CLK_NS;

   // ****************************************
   // Controller states
   // ****************************************
   typedef enum logic [3:0] {
      NSR_PWRUP = 4'h0,
      NSR_IDLE = 4'h1,
      NSR_READ = 4'h2,
      NSR_WR_SETUP = 4'h3,
      NSR_WR_PULSE = 4'h4,
      NSR_WR_END = 4'h5,
      NSR_ST_PULSE = 4'h6,
      NSR_ST_WAIT = 4'h7,
      NSR_RECOVER = 4'h8
   } nsr_state_t;
endpackage

/* src/nsr_host.sv */
`timescale 1ns/1ps
module nsr_host #(
   parameter int RECALL_WAIT = nsr_pkg::RECALL_CYC,
   parameter int STORE_WAIT = nsr_pkg::STORE_CYC
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [nsr_pkg::ADDR_W-1:0] req_addr,
   input wire logic [nsr_pkg::DATA_W-1:0] req_wdata,
   output logic req_ready,
   input wire logic store_req,
   output logic rsp_valid,
   output logic [nsr_pkg::DATA_W-1:0] rsp_rdata,
   output logic store_done,
   output logic store_late,
   output logic nvm_busy,
   output logic cs_n,
   output logic oe_n,
   output logic mem_put_n,
   output logic [nsr_pkg::ADDR_W-1:0] addr_lines,
   input wire logic [nsr_pkg::DATA_W-1:0] io_byte_i,
   output logic [nsr_pkg::DATA_W-1:0] io_byte_o,
   output logic io_byte_oe,
   input wire logic nv_save_busy_n_i,
   output logic nv_save_busy_n_o,
   output logic nv_save_busy_n_oe
);
   localparam int AW = nsr_pkg::ADDR_W;
   localparam int DW = nsr_pkg::DATA_W;
   localparam int CW = nsr_pkg::CNT_W;

   // Counter must hold the longest wait
   if (RECALL_WAIT < 1 || STORE_WAIT < 1 || RECALL_WAIT >= (1 << CW) || STORE_WAIT >= (1 << CW))
   begin : g_bad_param
      $error("nsr_host: wait parameters out of counter range");
   end

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [2:0] bsy_sync_ff;
   logic busy_seen_ff;
   logic [DW-1:0] din1_ff, din2_ff, din3_ff;

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         bsy_sync_ff <= 3'h7;
         busy_seen_ff <= 1'b0;
         din1_ff <= '0;
         din2_ff <= '0;
         din3_ff <= '0;
      end
      else
      begin
         bsy_sync_ff <= {bsy_sync_ff[1:0], nv_save_busy_n_i};
         // Change counts once stages two and three agree
         if (bsy_sync_ff[1] == bsy_sync_ff[2])
         begin
            busy_seen_ff <= ~bsy_sync_ff[2];
         end
         din1_ff <= io_byte_i;
         din2_ff <= din1_ff;
         din3_ff <= din2_ff;
      end
   end

   // ****************************************
   // Access and store sequencer
   // ****************************************
   nsr_pkg::nsr_state_t state_ff, nxt_state;
   logic [CW-1:0] cnt_ff, nxt_cnt;
   logic cs_n_ff, nxt_cs_n, oe_n_ff, nxt_oe_n, we_n_ff, nxt_we_n;
   logic [AW-1:0] addr_ff, nxt_addr;
   logic [DW-1:0] dout_ff, nxt_dout, rdata_ff, nxt_rdata;
   logic doe_ff, nxt_doe, hsb_oe_ff, nxt_hsb_oe;
   logic rsp_ff, nxt_rsp, done_ff, nxt_done, late_ff, nxt_late;

   always_comb
   begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff + 1'b1;
      nxt_cs_n = cs_n_ff;
      nxt_oe_n = oe_n_ff;
      nxt_we_n = 1'b1;
      nxt_addr = addr_ff;
      nxt_dout = dout_ff;
      nxt_doe = doe_ff;
      nxt_hsb_oe = 1'b0;
      nxt_rdata = rdata_ff;
      nxt_rsp = 1'b0;
      nxt_done = 1'b0;
      nxt_late = 1'b0;
      case (state_ff)
         nsr_pkg::NSR_PWRUP:
         begin
            nxt_cs_n = 1'b1;
            if (cnt_ff >= CW'(RECALL_WAIT - 1))
            begin
               nxt_state = nsr_pkg::NSR_IDLE;
               nxt_cnt = '0;
            end
         end
         nsr_pkg::NSR_IDLE:
         begin
            nxt_cnt = '0;
            nxt_cs_n = 1'b1;
            nxt_oe_n = 1'b1;
            nxt_doe = 1'b0;
            if (busy_seen_ff)
            begin
               nxt_state = nsr_pkg::NSR_ST_WAIT;
            end
            else if (store_req)
            begin
               nxt_state = nsr_pkg::NSR_ST_PULSE;
               nxt_hsb_oe = 1'b1;
            end
            else if (req_valid && req_write)
            begin
               nxt_state = nsr_pkg::NSR_WR_SETUP;
               nxt_addr = req_addr;
               nxt_dout = req_wdata;
               nxt_doe = 1'b1;
               nxt_cs_n = 1'b0;
            end
            else if (req_valid)
            begin
               nxt_state = nsr_pkg::NSR_READ;
               nxt_addr = req_addr;
               nxt_cs_n = 1'b0;
               nxt_oe_n = 1'b0;
            end
         end
         nsr_pkg::NSR_READ:
         begin
            if (cnt_ff >= CW'(nsr_pkg::ACCESS_CYC + nsr_pkg::SYNC_CYC - 1))
            begin
               nxt_rdata = din3_ff;
               nxt_rsp = 1'b1;
               nxt_cs_n = 1'b1;
               nxt_oe_n = 1'b1;
               nxt_state = nsr_pkg::NSR_IDLE;
            end
         end
         nsr_pkg::NSR_WR_SETUP:
         begin
            nxt_we_n = 1'b0;
            nxt_cnt = '0;
            nxt_state = nsr_pkg::NSR_WR_PULSE;
         end
         nsr_pkg::NSR_WR_PULSE:
         begin
            nxt_we_n = 1'b0;
            // data held through the rising edge
            if (cnt_ff >= CW'(nsr_pkg::WPULSE_CYC - 1))
            begin
               nxt_we_n = 1'b1;
               nxt_state = nsr_pkg::NSR_WR_END;
            end
         end
         nsr_pkg::NSR_WR_END:
         begin
            // One cycle of hold before the bus is let go
            nxt_cs_n = 1'b1;
            nxt_doe = 1'b0;
            nxt_state = nsr_pkg::NSR_IDLE;
         end
         nsr_pkg::NSR_ST_PULSE:
         begin
            nxt_hsb_oe = 1'b1;
            if (cnt_ff >= CW'(nsr_pkg::HSB_PULSE_CYC - 1))
            begin
               nxt_hsb_oe = 1'b0;
               nxt_cnt = '0;
               nxt_state = nsr_pkg::NSR_ST_WAIT;
            end
         end
         nsr_pkg::NSR_ST_WAIT:
         begin
            // Skipped stores release early; give the line time to fall first
            if (!busy_seen_ff && cnt_ff >= CW'(nsr_pkg::HSB_LOW_CYC + nsr_pkg::SYNC_CYC))
            begin
               nxt_cnt = '0;
               nxt_state = nsr_pkg::NSR_RECOVER;
            end
            else if (cnt_ff == CW'(STORE_WAIT))
            begin
               nxt_late = 1'b1;
            end
            else if (cnt_ff > CW'(STORE_WAIT))
            begin
               nxt_cnt = cnt_ff;
            end
         end
         nsr_pkg::NSR_RECOVER:
         begin
            // device inhibited shortly after busy rises
            if (busy_seen_ff)
            begin
               nxt_state = nsr_pkg::NSR_ST_WAIT;
               nxt_cnt = '0;
            end
            else if (cnt_ff >= CW'(nsr_pkg::RECOVER_CYC - 1))
            begin
               nxt_done = 1'b1;
               nxt_state = nsr_pkg::NSR_IDLE;
            end
         end
         default:
         begin
            nxt_state = nsr_pkg::NSR_IDLE;
            nxt_cnt = '0;
         end
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         state_ff <= nsr_pkg::NSR_PWRUP;
         cnt_ff <= '0;
         cs_n_ff <= 1'b1;
         oe_n_ff <= 1'b1;
         we_n_ff <= 1'b1;
         addr_ff <= '0;
         dout_ff <= '0;
         doe_ff <= 1'b0;
         hsb_oe_ff <= 1'b0;
         rdata_ff <= '0;
         rsp_ff <= 1'b0;
         done_ff <= 1'b0;
         late_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         cs_n_ff <= nxt_cs_n;
         oe_n_ff <= nxt_oe_n;
         we_n_ff <= nxt_we_n;
         addr_ff <= nxt_addr;
         dout_ff <= nxt_dout;
         doe_ff <= nxt_doe;
         hsb_oe_ff <= nxt_hsb_oe;
         rdata_ff <= nxt_rdata;
         rsp_ff <= nxt_rsp;
         done_ff <= nxt_done;
         late_ff <= nxt_late;
      end
   end

   assign req_ready = (state_ff == nsr_pkg::NSR_IDLE) && !busy_seen_ff && !store_req;
   assign rsp_valid = rsp_ff;
   assign rsp_rdata = rdata_ff;
   assign store_done = done_ff;
   assign store_late = late_ff;
   assign nvm_busy = busy_seen_ff;
   assign cs_n = cs_n_ff;
   assign oe_n = oe_n_ff;
   assign mem_put_n = we_n_ff;
   assign addr_lines = addr_ff;
   assign io_byte_o = dout_ff;
   assign io_byte_oe = doe_ff;
   // Open drain: only ever pulls low
   assign nv_save_busy_n_o = 1'b0;
   assign nv_save_busy_n_oe = hsb_oe_ff;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   chk_wr_addr_stable: assert property (!mem_put_n |=> $stable(addr_lines) || mem_put_n)
      else $error("address moved during write");
   chk_wr_data_driven: assert property (!mem_put_n |-> io_byte_oe && !cs_n)
      else $error("write data not driven");
   chk_wr_data_hold: assert property ($rose(mem_put_n) |-> io_byte_oe && $stable(io_byte_o))
      else $error("write data dropped at end edge");
   chk_wr_oe_high: assert property (!mem_put_n |-> oe_n)
      else $error("oe_n low during write");
   chk_pwrup_desel: assert property (state_ff == nsr_pkg::NSR_PWRUP |-> cs_n && mem_put_n)
      else $error("selected during power-up recall");
   chk_rd_wait: assert property ($fell(oe_n) |-> !oe_n[*6] ##1 rsp_valid)
      else $error("read answered at wrong time");
   chk_busy_block: assert property (busy_seen_ff && state_ff == nsr_pkg::NSR_IDLE |=> cs_n)
      else $error("access started while busy");
   chk_recover_gap: assert property ($fell(busy_seen_ff) |-> cs_n[*8])
      else $error("access too soon after store");
   chk_wr_pulse: assert property ($fell(mem_put_n) |-> !mem_put_n[*2] ##1 $rose(mem_put_n))
      else $error("write pulse width wrong");

   cov_read: cover property (rsp_valid);
   cov_write: cover property ($rose(mem_put_n));
   cov_store: cover property (store_done);
   cov_late: cover property (store_late);
endmodule // nsr_host

/* test/nsr_dev_model.sv */
`timescale 1ns/1ps
// ****************
// Device model
// ****************
module nsr_dev_model #(
   parameter int STORE_LEN = 30,
   parameter int TRIP_LEN = 10,
   parameter int RECALL_LEN = 15,
   parameter bit INHIBIT = 1'b0
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic trip,
   input wire logic cs_n,
   input wire logic oe_n,
   input wire logic mem_put_n,
   input wire logic [nsr_pkg::ADDR_W-1:0] addr_lines,
   input wire logic [nsr_pkg::DATA_W-1:0] io_byte,
   input wire logic busy_line,
   output logic [nsr_pkg::DATA_W-1:0] dev_data,
   output logic dev_drive,
   output logic busy_drive
);
   logic [nsr_pkg::DATA_W-1:0] mem [0:2047];
   logic written_ff = 1'b0;
   logic wr_ok = 1'b0;
   int st_cnt = 0;
   int rc_cnt = 0;
   int dr_cnt = 0;
   // read drive gating, reads live on through the drain
   assign dev_drive = !cs_n && !oe_n && mem_put_n && (busy_line || dr_cnt != 0) && rc_cnt == 0;
   assign dev_data = mem[addr_lines];
   // a write begun before busy fell may still finish
   always @(negedge mem_put_n or negedge cs_n)
   begin
      if (!cs_n && !mem_put_n)
      begin
         wr_ok = busy_line && rc_cnt == 0;
      end
   end
   always @(posedge mem_put_n or posedge cs_n)
   begin
      if (wr_ok && (!cs_n || !mem_put_n))
      begin
         mem[addr_lines] = io_byte;
         written_ff = 1'b1;
         wr_ok = 1'b0;
      end
   end
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         rc_cnt <= RECALL_LEN;
         st_cnt <= 0;
         dr_cnt <= 0;
         busy_drive <= 1'b0;
      end
      else if (rc_cnt != 0)
      begin
         rc_cnt <= rc_cnt - 1;
         if (rc_cnt == 1) written_ff <= 1'b0;
      end
      else if (dr_cnt != 0)
      begin
         // drain window first; unwritten data skips the transfer
         dr_cnt <= dr_cnt - 1;
         if (dr_cnt == 1)
         begin
            st_cnt <= written_ff ? STORE_LEN : 0;
            busy_drive <= written_ff;
         end
      end
      // transfer length well inside the host's overrun limit
      else if (st_cnt != 0)
      begin
         st_cnt <= st_cnt - 1;
         busy_drive <= st_cnt > 1;
         if (st_cnt == 1) written_ff <= 1'b0;
      end
      // inhibit wiring leaves only pin requests
      else if ((trip && !INHIBIT) || (!busy_line && written_ff))
      begin
         // Unwritten trip only pulses the line, no transfer follows
         dr_cnt <= TRIP_LEN;
         busy_drive <= 1'b1;
      end
   end
endmodule // nsr_dev_model

/* test/tb_top.sv */
`timescale 1ns/1ps
// ****************
// Bench
// ****************
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
   $display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb_top;
   logic clk_sys = 1'b0, rst = 1'b1, req_valid = 1'b0, req_write = 1'b0, store_req = 1'b0, trip = 1'b0;
   logic hold_busy = 1'b0;
   logic [nsr_pkg::ADDR_W-1:0] req_addr = '0, addr_lines;
   logic [nsr_pkg::DATA_W-1:0] req_wdata = '0, rsp_rdata, io_byte_o, io_byte_i, dev_data, last_q = 8'h00;
   logic req_ready, rsp_valid, store_done, store_late, nvm_busy, cs_n, oe_n, mem_put_n, io_byte_oe;
   logic nv_save_busy_n_i, nv_save_busy_n_o, nv_save_busy_n_oe, dev_drive, busy_drive, seen;
   int errors = 0, checks = 0, n = 0, cyc = 0;
   always #10 clk_sys = ~clk_sys;
   // Undriven bus shows the inverse of its last value; busy has a pull-up and three pullers (host, device, hold_busy)
   always @(posedge clk_sys) last_q <= io_byte_i;
   assign io_byte_i = io_byte_oe ? io_byte_o : dev_drive ? dev_data : ~last_q;
   assign nv_save_busy_n_i = !(nv_save_busy_n_oe && !nv_save_busy_n_o) && !busy_drive && !hold_busy;
   nsr_host #(.RECALL_WAIT(20), .STORE_WAIT(50)) nsr_host_i (.clk_sys, .rst, .req_valid, .req_write,
      .req_addr, .req_wdata, .req_ready, .store_req, .rsp_valid, .rsp_rdata, .store_done, .store_late,
      .nvm_busy, .cs_n, .oe_n, .mem_put_n, .addr_lines, .io_byte_i, .io_byte_o, .io_byte_oe,
      .nv_save_busy_n_i, .nv_save_busy_n_o, .nv_save_busy_n_oe);
   nsr_dev_model nsr_dev_model_i (.clk_sys, .rst, .trip, .cs_n, .oe_n, .mem_put_n, .addr_lines,
      .io_byte(io_byte_i), .busy_line(nv_save_busy_n_i), .dev_data, .dev_drive, .busy_drive);
   task automatic wait_ready();
      n = 0;
      @(negedge clk_sys);
      while (req_ready !== 1'b1 && n < 100)
      begin
         n++;
         @(negedge clk_sys);
      end
      `CHK(req_ready, 1'b1)
   endtask
   task automatic access(input logic w, input logic [10:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      req_valid <= 1'b1;
      req_write <= w;
      req_addr <= a;
      req_wdata <= d;
      wait_ready();
      @(posedge clk_sys);
      req_valid <= 1'b0;
   endtask
   task automatic rd_chk(input logic [10:0] a, input logic [7:0] exp);
      access(1'b0, a, 8'h00);
      n = 0;
      do begin @(negedge clk_sys); n++; end while (rsp_valid !== 1'b1 && n < 20);
      `CHK(n, nsr_pkg::ACCESS_CYC + nsr_pkg::SYNC_CYC + 1)
      `CHK(rsp_rdata, exp)
   endtask
   // Watches busy for the whole sequence; writes must stay refused meanwhile
   task automatic wait_done();
      cyc = 0;
      seen = 1'b0;
      do
      begin
         @(negedge clk_sys);
         cyc++;
         if (nvm_busy === 1'b1) seen = 1'b1;
         if (nvm_busy === 1'b1) `CHK(req_ready, 1'b0)
      end
      while (store_done !== 1'b1 && cyc < 2000);
      `CHK(store_done, 1'b1)
   endtask
   task automatic pin_store();
      wait_ready();
      @(posedge clk_sys);
      store_req <= 1'b1;
      @(posedge clk_sys);
      store_req <= 1'b0;
      wait_done();
   endtask
   task automatic t_rw();
      access(1'b1, 11'h000, 8'ha5);
      access(1'b1, 11'h7ff, 8'h5a);
      access(1'b1, 11'h2aa, 8'h3c);
      rd_chk(11'h000, 8'ha5);
      rd_chk(11'h7ff, 8'h5a);
      rd_chk(11'h2aa, 8'h3c);
      $display("t_rw done");
   endtask
   task automatic t_pin();
      access(1'b1, 11'h010, 8'hff);
      pin_store();
      `CHK(seen, 1'b1)
      rd_chk(11'h010, 8'hff);
      pin_store();
      `CHK(seen, 1'b0)
      $display("t_pin done");
   endtask
   task automatic t_auto();
      access(1'b1, 11'h123, 8'h81);
      // Trip lands while that write is still under way
      @(posedge clk_sys);
      trip <= 1'b1;
      @(posedge clk_sys);
      trip <= 1'b0;
      wait_done();
      `CHK(seen, 1'b1)
      pin_store();
      `CHK(seen, 1'b0)
      @(posedge clk_sys);
      trip <= 1'b1;
      @(posedge clk_sys);
      trip <= 1'b0;
      wait_done();
      `CHK(seen, 1'b1)
      rd_chk(11'h123, 8'h81);
      $display("t_auto done");
   endtask
   // Line held low from outside past the overrun limit
   task automatic t_late();
      seen = 1'b0;
      @(posedge clk_sys);
      hold_busy <= 1'b1;
      repeat (70)
      begin
         @(negedge clk_sys);
         if (store_late === 1'b1) seen = 1'b1;
      end
      `CHK(seen, 1'b1)
      @(posedge clk_sys);
      hold_busy <= 1'b0;
      wait_done();
      `CHK(seen, 1'b1)
      $display("t_late done");
   endtask
   task automatic summarize();
      $display("checks=%0d errors=%0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      #200000;
      errors++;
      summarize();
   end
   initial
   begin
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      t_rw();
      t_pin();
      t_auto();
      t_late();
      summarize();
   end
endmodule // tb_top
